//--- rtl/ext_bus_pins.sv
// External memory bus pin engine with APB register access
module ext_bus_pins #(
  parameter logic [15:0] ONCHIP_CODE_SIZE = 16'h4000  // On-chip code bytes
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        code_source_select,
  output logic             addr_latch_strobe,
  output logic             program_read_strobe_n,
  output logic             data_read_strobe_n,
  output logic             data_write_strobe_n,
  input  wire logic [7:0]  port_zero_pins_in,
  output logic      [7:0]  port_zero_pins_out,
  output logic      [7:0]  port_zero_pins_oe_n,
  input  wire logic [7:0]  port_two_pins_in,
  output logic      [7:0]  port_two_pins_out,
  output logic      [7:0]  port_two_pins_oe_n
);
  // Software-visible state
  logic [7:0]  ctrl_r;          // Page mode, read range, wait states
  logic [7:0]  port0_latch_r;   // General I/O latch, port zero
  logic [7:0]  port2_latch_r;   // General I/O latch, port two
  logic [15:0] bus_addr_r;      // Address of next bus cycle
  logic [7:0]  bus_wdata_r;     // Data of next write cycle
  logic [7:0]  bus_rdata_r;     // Data of last read or fetch
  logic        internal_r;      // Last command was a fetch served on chip
  logic        prog_used_r;     // Last cycle used program strobe
  // Strap capture
  logic        strap_sync;      // Synchronised select level
  logic        strap_r;         // Level held until next reset
  logic        strap_taken_r;   // Capture done
  logic [1:0]  strap_cnt_r;     // Edges since reset release
  // Synchronised port inputs
  logic [7:0]  p0_sync;
  logic [7:0]  p2_sync;
  // Bus engine
  ext_bus_pkg::bus_state_t state_r;
  ext_bus_pkg::bus_state_t state_nxt;
  logic [1:0]  kind_r;          // Kind of cycle under way
  logic        prog_strobe_r;   // Cycle uses program strobe
  logic [2:0]  cnt_r;           // Strobe-phase cycles left
  logic        page_r;          // Page mode frozen for the cycle
  // APB decode
  logic        setup_phase;
  logic        access_wr;
  logic        cmd_write;
  logic        mapped;
  logic [31:0] rd_mux;
  // Fetch decode
  logic        fetch_internal;
  logic        in_read_range;
  logic        cmd_kind_ok;
  logic        start_ext;
  // Pin drive values decoded from state
  logic        p0_own;
  logic        p0_drive;
  logic [7:0]  p0_val;
  logic        p2_own;
  logic        p2_drive;
  logic [7:0]  p2_val;

  sync2 #(.WIDTH(1)) u_sync_strap (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (code_source_select),
    .sync_out (strap_sync)
  );

  sync2 #(.WIDTH(16)) u_sync_ports (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({port_two_pins_in, port_zero_pins_in}),
    .sync_out ({p2_sync, p0_sync})
  );

  // Select level is sampled once, after the synchroniser has filled;
  // later pin changes are ignored until the next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_r   <= 2'h0;
      strap_taken_r <= 1'b0;
      strap_r       <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == ext_bus_pkg::STRAP_DELAY_CYCLES - 2'h1) begin
        strap_taken_r <= 1'b1;  // [R7]
        strap_r       <= strap_sync;  // [R7]
      end
    end
  end

  // APB phases; pready answers in the first access cycle
  assign setup_phase = psel && !penable;
  assign access_wr   = psel && penable && pready && pwrite;
  assign cmd_write   = access_wr && (paddr == ext_bus_pkg::OFS_BUS_CMD);

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == ext_bus_pkg::OFS_CTRL) begin
      rd_mux[7:0] = ctrl_r;
    end else if (paddr == ext_bus_pkg::OFS_PORT0_OUT) begin
      rd_mux[7:0] = port0_latch_r;
    end else if (paddr == ext_bus_pkg::OFS_PORT2_OUT) begin
      rd_mux[7:0] = port2_latch_r;
    end else if (paddr == ext_bus_pkg::OFS_PIN_IN) begin
      rd_mux[15:0] = {p2_sync, p0_sync};
    end else if (paddr == ext_bus_pkg::OFS_BUS_ADDR) begin
      rd_mux[15:0] = bus_addr_r;
    end else if (paddr == ext_bus_pkg::OFS_BUS_WDATA) begin
      rd_mux[7:0] = bus_wdata_r;
    end else if (paddr == ext_bus_pkg::OFS_BUS_CMD) begin
      rd_mux = 32'h0000_0000;  // Write-only trigger, reads zero
    end else if (paddr == ext_bus_pkg::OFS_BUS_STAT) begin
      rd_mux[ext_bus_pkg::STAT_BUSY_BIT]  = (state_r != ext_bus_pkg::ST_IDLE);
      rd_mux[ext_bus_pkg::STAT_INT_BIT]   = internal_r;
      rd_mux[ext_bus_pkg::STAT_STRAP_BIT] = strap_r;
      rd_mux[ext_bus_pkg::STAT_PROG_BIT]  = prog_used_r;
      rd_mux[ext_bus_pkg::STAT_DATA_LSB +: 8] = bus_rdata_r;
    end else begin
      mapped = 1'b0;  // Unmapped: error answer, data zero
    end
  end

  // Answer registers: loaded in setup, held through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup_phase) begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Writable registers; address and data are locked while a cycle runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r        <= ext_bus_pkg::CTRL_RESET;
      port0_latch_r <= ext_bus_pkg::PORT_RESET;
      port2_latch_r <= ext_bus_pkg::PORT_RESET;
      bus_addr_r    <= 16'h0000;
      bus_wdata_r   <= 8'h00;
    end else if (access_wr) begin
      if (paddr == ext_bus_pkg::OFS_CTRL) begin
        ctrl_r <= pwdata[7:0];
      end else if (paddr == ext_bus_pkg::OFS_PORT0_OUT) begin
        port0_latch_r <= pwdata[7:0];
      end else if (paddr == ext_bus_pkg::OFS_PORT2_OUT) begin
        port2_latch_r <= pwdata[7:0];
      end else if (paddr == ext_bus_pkg::OFS_BUS_ADDR && state_r == ext_bus_pkg::ST_IDLE) begin
        bus_addr_r <= pwdata[15:0];
      end else if (paddr == ext_bus_pkg::OFS_BUS_WDATA && state_r == ext_bus_pkg::ST_IDLE) begin
        bus_wdata_r <= pwdata[7:0];
      end
    end
  end

  // Code fetch routing: strap low sends everything out, strap high keeps
  // the on-chip range inside
  assign fetch_internal = strap_r && (bus_addr_r < ONCHIP_CODE_SIZE);  // [R5] [R6]

  // Read range from the two range bits: 00 none, 01 lower half,
  // 10 upper half, 11 whole space
  always_comb begin
    case ({ctrl_r[ext_bus_pkg::CTRL_RD_HI_BIT], ctrl_r[ext_bus_pkg::CTRL_RD_LO_BIT]})
      2'h0:    in_read_range = 1'b0;
      2'h1:    in_read_range = !bus_addr_r[15];
      2'h2:    in_read_range = bus_addr_r[15];
      default: in_read_range = 1'b1;
    endcase
  end

  assign cmd_kind_ok = (pwdata[1:0] != 2'h3);
  assign start_ext   = cmd_write && strap_taken_r && cmd_kind_ok && (state_r == ext_bus_pkg::ST_IDLE)
                       && !(pwdata[1:0] == ext_bus_pkg::CMD_CODE_FETCH && fetch_internal);

  // Bus state sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ext_bus_pkg::ST_IDLE:   if (start_ext) state_nxt = ext_bus_pkg::ST_ALE;
      ext_bus_pkg::ST_ALE:    state_nxt = ext_bus_pkg::ST_HOLD;
      ext_bus_pkg::ST_HOLD:   state_nxt = ext_bus_pkg::ST_STROBE;
      ext_bus_pkg::ST_STROBE: if (cnt_r == 3'h1) state_nxt = ext_bus_pkg::ST_END;
      default:                state_nxt = ext_bus_pkg::ST_IDLE;
    endcase
  end

  // Engine state, cycle kind and strobe timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r       <= ext_bus_pkg::ST_IDLE;
      kind_r        <= ext_bus_pkg::CMD_CODE_FETCH;
      prog_strobe_r <= 1'b0;
      page_r        <= 1'b0;
      cnt_r         <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (start_ext) begin
        kind_r        <= pwdata[1:0];
        // Code fetches outside the read range fall back to the data strobe
        prog_strobe_r <= (pwdata[1:0] == ext_bus_pkg::CMD_CODE_FETCH) && in_read_range;  // [R11]
        page_r        <= ctrl_r[ext_bus_pkg::CTRL_PAGE_BIT];
      end
      if (state_r == ext_bus_pkg::ST_HOLD) begin
        cnt_r <= ext_bus_pkg::STROBE_BASE_CYCLES + {1'b0, ctrl_r[ext_bus_pkg::CTRL_WS_LSB +: 2]};
      end else if (state_r == ext_bus_pkg::ST_STROBE) begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end

  // Result flags. Read data is taken as the engine leaves the strobe, so the
  // level handed over by the synchroniser was on the pins at least one cycle
  // after the strobe fell; earlier, zero wait states would catch the address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_rdata_r <= 8'h00;
      internal_r  <= 1'b0;
      prog_used_r <= 1'b0;
    end else if (cmd_write && strap_taken_r && cmd_kind_ok && state_r == ext_bus_pkg::ST_IDLE) begin
      internal_r  <= (pwdata[1:0] == ext_bus_pkg::CMD_CODE_FETCH) && fetch_internal;  // [R6]
      prog_used_r <= (pwdata[1:0] == ext_bus_pkg::CMD_CODE_FETCH) && in_read_range && !fetch_internal;
    end else if (state_r == ext_bus_pkg::ST_END && kind_r != ext_bus_pkg::CMD_DATA_WRITE) begin
      bus_rdata_r <= page_r ? p2_sync : p0_sync;  // [R3] [R4]
    end
  end

  // Line ownership per phase. Non-page: port zero carries low address
  // then data, port two the upper address. Page: port zero keeps the low
  // address, port two carries upper address then data.
  always_comb begin
    p0_own   = (state_r != ext_bus_pkg::ST_IDLE);
    p2_own   = (state_r != ext_bus_pkg::ST_IDLE);
    p0_drive = 1'b1;
    p2_drive = 1'b1;
    p0_val   = bus_addr_r[7:0];
    p2_val   = bus_addr_r[15:8];
    if (state_r == ext_bus_pkg::ST_STROBE || state_r == ext_bus_pkg::ST_END) begin
      if (page_r) begin
        p2_val   = bus_wdata_r;  // [R4]
        p2_drive = (kind_r == ext_bus_pkg::CMD_DATA_WRITE);
      end else begin
        p0_val   = bus_wdata_r;  // [R3]
        p0_drive = (kind_r == ext_bus_pkg::CMD_DATA_WRITE);
      end
    end
  end

  // Port zero: bus lines or open-drain general I/O when idle
  port_pin_driver #(.WIDTH(8)) u_port_zero (
    .pclk      (pclk),
    .presetn   (presetn),
    .bus_own   (p0_own),
    .bus_drive (p0_drive),
    .bus_val   (p0_val),
    .gpio_val  (port0_latch_r),  // [R9]
    .pin_out   (port_zero_pins_out),
    .pin_oe_n  (port_zero_pins_oe_n)
  );

  // Port two: bus lines or open-drain general I/O when idle, as port zero
  port_pin_driver #(.WIDTH(8)) u_port_two (
    .pclk      (pclk),
    .presetn   (presetn),
    .bus_own   (p2_own),
    .bus_drive (p2_drive),
    .bus_val   (p2_val),
    .gpio_val  (port2_latch_r),  // [R10]
    .pin_out   (port_two_pins_out),
    .pin_oe_n  (port_two_pins_oe_n)
  );

  // Strobes are registered from state, so they move with the port lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_latch_strobe     <= 1'b0;
      program_read_strobe_n <= 1'b1;
      data_read_strobe_n    <= 1'b1;
      data_write_strobe_n   <= 1'b1;
    end else begin
      // Address latch high for the first cycle while address is valid
      addr_latch_strobe     <= (state_r == ext_bus_pkg::ST_ALE);  // [R1] [R2]
      program_read_strobe_n <= !(state_r == ext_bus_pkg::ST_STROBE && prog_strobe_r);  // [R11]
      data_read_strobe_n    <= !(state_r == ext_bus_pkg::ST_STROBE && !prog_strobe_r
                                 && kind_r != ext_bus_pkg::CMD_DATA_WRITE);  // [R12]
      data_write_strobe_n   <= !(state_r == ext_bus_pkg::ST_STROBE
                                 && kind_r == ext_bus_pkg::CMD_DATA_WRITE);
    end
  end
endmodule

//--- rtl/ext_bus_pkg.sv
// Constants shared by the external memory bus pin block
// What this block does
// [R1] Strobe address latch at each bus cycle start
// [R2] Outside latch captures low address on strobe
// [R3] Non-page: low address and data share port zero
// [R4] Page: low address port zero, data port two
// [R5] Select low: all code fetches go external
// [R6] Select high: on-chip range served internally
// [R7] Select level caught at reset, then held
// [R8] No on-chip code: select tied low
// [R9] Idle port zero is open-drain general I/O
// [R10] Idle port two is pulled-up general I/O; the code drives it open-drain, the same way as port zero
// [R11] Program strobe only inside configured read range
// [R12] Separate active-low strobe for data reads
package ext_bus_pkg;
  // APB byte addresses
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_PORT0_OUT = 8'h04;
  localparam logic [7:0] OFS_PORT2_OUT = 8'h08;
  localparam logic [7:0] OFS_PIN_IN    = 8'h0C;
  localparam logic [7:0] OFS_BUS_ADDR  = 8'h10;
  localparam logic [7:0] OFS_BUS_WDATA = 8'h14;
  localparam logic [7:0] OFS_BUS_CMD   = 8'h18;
  localparam logic [7:0] OFS_BUS_STAT  = 8'h1C;
  // Control register fields
  localparam int CTRL_PAGE_BIT  = 0;
  localparam int CTRL_RD_LO_BIT = 1;
  localparam int CTRL_RD_HI_BIT = 2;
  localparam int CTRL_WS_LSB    = 4;
  // Status register fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_INT_BIT   = 1;
  localparam int STAT_STRAP_BIT = 2;
  localparam int STAT_PROG_BIT  = 3;
  localparam int STAT_DATA_LSB  = 8;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h06;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  // Bus cycle timing in pclk cycles
  localparam logic [2:0] STROBE_BASE_CYCLES = 3'h3;
  localparam logic [1:0] STRAP_DELAY_CYCLES = 2'h3;
  // Bus command kinds
  localparam logic [1:0] CMD_CODE_FETCH = 2'h0;
  localparam logic [1:0] CMD_DATA_READ  = 2'h1;
  localparam logic [1:0] CMD_DATA_WRITE = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_ALE, ST_HOLD, ST_STROBE, ST_END} bus_state_t;
endpackage

//--- rtl/sync2.sv
// Two-stage synchroniser for pin inputs
module sync2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;  // First stage, read only by the second

  // Both stages clear to zero; the pin level appears two edges later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

//--- rtl/port_pin_driver.sv
// Registered pin driver: bus value or general I/O latch
module port_pin_driver #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             bus_own,
  input  wire logic             bus_drive,
  input  wire logic [WIDTH-1:0] bus_val,
  input  wire logic [WIDTH-1:0] gpio_val,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe_n
);
  // Bus owns the lines: drive both levels or release for read data.
  // General I/O: drive only zeros, a one is left to the pull-up so the
  // same line can be read as an input.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out  <= '1;
      pin_oe_n <= '1;
    end else if (bus_own) begin
      pin_out  <= bus_val;
      pin_oe_n <= {WIDTH{~bus_drive}};
    end else begin
      pin_out  <= gpio_val;
      pin_oe_n <= gpio_val;
    end
  end
endmodule

//--- tb/ext_bus_pins_props.sv
// Checker for the external bus pin block, bound to its ports
module ext_bus_pins_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       addr_latch_strobe,
  input wire logic       program_read_strobe_n,
  input wire logic       data_read_strobe_n,
  input wire logic       data_write_strobe_n,
  input wire logic [7:0] port_zero_pins_out,
  input wire logic [7:0] port_zero_pins_oe_n,
  input wire logic [7:0] port_two_pins_out,
  input wire logic [7:0] port_two_pins_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  wire        ale  = addr_latch_strobe;    // Short alias
  wire  [7:0] z_oe = port_zero_pins_oe_n;  // Short alias
  wire  [7:0] t_oe = port_two_pins_oe_n;   // Short alias
  wire        hi   = program_read_strobe_n & data_read_strobe_n & data_write_strobe_n;  // No strobe low
  wire        rd   = !(program_read_strobe_n & data_read_strobe_n);                    // Any read strobe low
  logic [1:0] idle_r;  // Quiet cycles, saturating
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Pins lag the bus engine, so general I/O is only judged after a few quiet cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_r <= 2'h0;
    else if (ale || !hi) idle_r <= 2'h0;
    else if (idle_r != 2'h3) idle_r <= idle_r + 2'h1;
  end
  property p_ale_pulse;
    $rose(ale) |=> !ale [*4];
  endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("latch strobe too long");
  property p_ale_pins;
    ale |-> z_oe == 8'h00 && t_oe == 8'h00;
  endproperty
  a_ale_pins: assert property (p_ale_pins) else $error("address not driven at latch");
  property p_addr_hold;
    ale |=> $stable(port_zero_pins_out) && $stable(port_two_pins_out) && hi;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address not held");
  property p_strobe_after;
    ale |-> ##2 !hi;
  endproperty
  a_strobe_after: assert property (p_strobe_after) else $error("no strobe after latch");
  property p_one_strobe;
    $onehot0({!program_read_strobe_n, !data_read_strobe_n, !data_write_strobe_n});
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("two strobes low");
  property p_strobe_len;
    $fell(hi) |-> !hi [*3];
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe too short");
  property p_rd_turn;
    rd |-> (z_oe == 8'hFF) != (t_oe == 8'hFF);
  endproperty
  a_rd_turn: assert property (p_rd_turn) else $error("wrong port released on read");
  property p_wr_drive;
    !data_write_strobe_n |-> z_oe == 8'h00 && t_oe == 8'h00;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("port released on write");
  property p_idle_io;
    idle_r == 2'h3 && !ale && hi |-> (~z_oe & port_zero_pins_out) == 8'h00 && (~t_oe & port_two_pins_out) == 8'h00;
  endproperty
  a_idle_io: assert property (p_idle_io) else $error("idle pin driven high");
  c_fetch: cover property ($fell(program_read_strobe_n));
  c_read: cover property ($fell(data_read_strobe_n));
  c_write: cover property ($fell(data_write_strobe_n));
endmodule
bind ext_bus_pins ext_bus_pins_props chk_u (.pclk, .presetn, .addr_latch_strobe, .program_read_strobe_n,
  .data_read_strobe_n, .data_write_strobe_n, .port_zero_pins_out, .port_zero_pins_oe_n,
  .port_two_pins_out, .port_two_pins_oe_n);

//--- tb/ext_mem_model.sv
// Behavioural external memory with address latch
module ext_mem_model (
  input  wire logic       pclk,
  input  wire logic       page,   // Data rides on port two
  input  wire logic       slow,   // Data settles one cycle into the strobe
  input  wire logic       ale,
  input  wire logic       prs_n,
  input  wire logic       drs_n,
  input  wire logic       dws_n,
  input  wire logic [7:0] p0,
  input  wire logic [7:0] p2,
  output logic            d_en,
  output logic      [7:0] d_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [65536];  // Starts as a fold of the address
  logic [15:0] lat;          // Latched address
  int          lag;          // Cycles into the read strobe
  initial foreach (mem[i]) mem[i] = i[7:0] ^ i[15:8];
  assign d_en = !(prs_n && drs_n);
  // A slow part shows garbage before its access time, never stale data
  assign d_out = slow && lag == 0 ? ~mem[lat] : mem[lat];
  // Address caught while the latch strobe is high
  always @(posedge pclk) begin
    if (ale) lat <= {p2, p0};
    lag <= d_en ? lag + 1 : 0;
    if (!dws_n) mem[lat] <= page ? p2 : p0;
  end
endmodule

//--- tb/tb_external_memory_bus_pins.sv
// Self-checking bench for the external memory bus pin block
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module tb_external_memory_bus_pins;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] ONCHIP = 16'h4000;  // On-chip code size used here
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, csel = 1'h1;
  logic        page = 1'h0, slow = 1'h0, serr, pready, pslverr, ale, prs_n, drs_n, dws_n, d_en;
  logic [7:0]  paddr = 8'h00, p0_in, p0_out, p0_oe_n, p2_in, p2_out, p2_oe_n, d_out, v;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [7:0]  exp_mem [int];  // Bytes written to external memory
  int          err_count = 0, total_checks = 0, seed, n_ale = 0, n_prs = 0, n_drs = 0, n_dws = 0, k, w, r;
  always #20 pclk = ~pclk;
  // Pins resolve from the block, the memory and pull-ups
  assign p0_in = ~p0_oe_n & p0_out | p0_oe_n & (d_en && !page ? d_out : 8'hFF);
  assign p2_in = ~p2_oe_n & p2_out | p2_oe_n & (d_en && page ? d_out : 8'hFF);
  always @(posedge ale) n_ale++;
  always @(negedge prs_n) n_prs++;
  always @(negedge drs_n) n_drs++;
  always @(negedge dws_n) n_dws++;
  ext_bus_pins #(.ONCHIP_CODE_SIZE(ONCHIP)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .code_source_select(csel), .addr_latch_strobe(ale), .program_read_strobe_n(prs_n),
    .data_read_strobe_n(drs_n), .data_write_strobe_n(dws_n), .port_zero_pins_in(p0_in), .port_zero_pins_out(p0_out),
    .port_zero_pins_oe_n(p0_oe_n), .port_two_pins_in(p2_in), .port_two_pins_out(p2_out), .port_two_pins_oe_n(p2_oe_n));
  ext_mem_model mem_u (.pclk, .page, .slow, .ale, .prs_n, .drs_n, .dws_n, .p0(p0_out), .p2(p2_out), .d_en, .d_out);
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // A wait that runs out ends the run
  task automatic hang(input string what);
    `CHK(what, 1'h0, 1'h1)
    tally_and_finish();
  endtask
  task automatic rst(input logic s);
    presetn <= 1'h0;
    csel <= s;
    page <= 1'h0;
    slow <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
  endtask
  // Setup cycle, then access held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d = 32'h0);
    int n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1 && ++n < 16);
    if (pready !== 1'h1) hang("pready");
    rdat = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // One bus command, polled until idle; leaves the status word in rdat
  task automatic op(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d = 8'h00, input int ales = 1);
    int n = 0;
    int e = n_ale;
    apb(1'h1, ext_bus_pkg::OFS_BUS_ADDR, {16'h0, a});
    apb(1'h1, ext_bus_pkg::OFS_BUS_WDATA, {24'h0, d});
    apb(1'h1, ext_bus_pkg::OFS_BUS_CMD, {30'h0, c});
    do apb(1'h0, ext_bus_pkg::OFS_BUS_STAT); while (rdat[ext_bus_pkg::STAT_BUSY_BIT] !== 1'h0 && ++n < 20);
    if (rdat[ext_bus_pkg::STAT_BUSY_BIT] !== 1'h0) hang("busy");
    `CHK("ale count", ales, n_ale - e)
  endtask
  function automatic logic [7:0] exp_b(input logic [15:0] a);
    return exp_mem.exists(a) ? exp_mem[a] : a[7:0] ^ a[15:8];
  endfunction
  // External code fetch: strobe kind follows the read range
  task automatic fetch(input logic [15:0] a, input logic [1:0] rng);
    int p = n_prs;
    int q = n_drs;
    logic in_rng = rng == 2'h3 || rng == 2'h1 && a < 16'h8000 || rng == 2'h2 && a >= 16'h8000;
    op(ext_bus_pkg::CMD_CODE_FETCH, a);
    `CHK("prog strobe", in_rng, n_prs - p == 1)
    `CHK("data strobe", !in_rng, n_drs - q == 1)
    `CHK("stat prog", in_rng, rdat[ext_bus_pkg::STAT_PROG_BIT])
    `CHK("fetch data", exp_b(a), rdat[15:8])
  endtask
  initial begin
    seed = 39138;
    rst(1'h1);
    apb(1'h0, ext_bus_pkg::OFS_CTRL);
    `CHK("ctrl reset", {24'h0, ext_bus_pkg::CTRL_RESET}, rdat)
    `CHK("mapped", 1'h0, serr)
    apb(1'h0, 8'h20);
    `CHK("unmapped", 1'h1, serr)
    $display("done registers");
    v = $random(seed);
    apb(1'h1, ext_bus_pkg::OFS_PORT0_OUT, {24'h0, v});
    apb(1'h1, ext_bus_pkg::OFS_PORT2_OUT, {24'h0, ~v});
    csel <= 1'h0;
    repeat (3) @(posedge pclk);
    `CHK("p0 drive", v, p0_oe_n)
    `CHK("p2 drive", ~v, p2_oe_n)
    apb(1'h0, ext_bus_pkg::OFS_PIN_IN);
    `CHK("pins in", {~v, v}, rdat[15:0])
    $display("done general io");
    op(ext_bus_pkg::CMD_CODE_FETCH, ONCHIP - 16'h1, 8'h00, 0);
    `CHK("internal", 2'h3, {rdat[ext_bus_pkg::STAT_INT_BIT], rdat[ext_bus_pkg::STAT_STRAP_BIT]})
    fetch(ONCHIP, 2'h3);
    // Reserved command kind must start no bus cycle
    op(2'h3, ONCHIP, 8'h00, 0);
    // Every range, both layouts, random wait states, prompt and slow memory;
    // a slow part always gets at least one wait state, as a system would give it
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      page <= i[0];
      slow <= i[3];
      apb(1'h1, ext_bus_pkg::OFS_CTRL, {26'h0, v[5], v[4] | i[3], 1'h0, i[2:1], i[0]});
      k = $random(seed);
      fetch({k[15], 1'h1, k[13:0]}, i[2:1]);
      w = n_dws;
      r = n_drs;
      op(ext_bus_pkg::CMD_DATA_WRITE, k[31:16], v);
      exp_mem[k[31:16]] = v;
      op(ext_bus_pkg::CMD_DATA_READ, k[31:16]);
      `CHK("read back", exp_b(k[31:16]), rdat[15:8])
      `CHK("strobe use", 2'h3, {n_dws - w == 1, n_drs - r == 1})
    end
    $display("done bus cycles");
    rst(1'h0);
    fetch(16'h0000, 2'h3);
    `CHK("strap low", 1'h0, rdat[ext_bus_pkg::STAT_STRAP_BIT])
    $display("done strap low");
    tally_and_finish();
  end
endmodule
